// *** hw/pvi_pkg.sv ***
package pvi_pkg;
    localparam int NUM_SRC      = 15;
    localparam int NUM_EXT      = 9;
    localparam int NUM_INT      = 6;
    localparam int VEC_W        = 16;
    localparam int AXI_AW       = 8;
    localparam int AXI_DW       = 32;

    // Register byte offsets
    localparam logic [AXI_AW-1:0] OFS_FLAG_A   = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_FLAG_B   = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_FLAG_C   = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_ENABLE_A = 8'h0C;
    localparam logic [AXI_AW-1:0] OFS_ENABLE_B = 8'h10;
    localparam logic [AXI_AW-1:0] OFS_STATUS   = 8'h14;
    localparam logic [AXI_AW-1:0] OFS_SET_TEST = 8'h18;

    // Source indices, index = priority level - 1
    localparam int SRC_WDT    = 0;
    localparam int SRC_EXT_A  = 1;
    localparam int SRC_MTMR   = 2;
    localparam int SRC_EXT_B  = 3;
    localparam int SRC_TBASE  = 4;
    localparam int SRC_UTX    = 5;
    localparam int SRC_URX    = 6;
    localparam int SRC_UERR   = 7;
    localparam int SRC_TMR3   = 8;
    localparam int SRC_SPI    = 9;
    localparam int SRC_TMR4   = 10;
    localparam int SRC_EXT_C  = 11;
    localparam int SRC_ADC    = 12;
    localparam int SRC_TMR2   = 13;
    localparam int SRC_EXT_D  = 14;

    // Flag register split: a holds 0..4, b holds 5..9, c holds 10..14
    localparam int FLAG_A_LO  = 0;
    localparam int FLAG_B_LO  = 5;
    localparam int FLAG_C_LO  = 10;
    localparam int FLAG_W     = 5;
    // Enable register split: a holds 0..7, b holds 8..14
    localparam int EN_A_W     = 8;
    localparam int EN_B_W     = 7;
    // Flag in register c that is only set when enabled (change flag)
    localparam int EXCL_SRC   = SRC_EXT_C;

    localparam logic [VEC_W-1:0] VEC_RESET = 16'h0000;
    localparam logic [VEC_W-1:0] VEC_TABLE [NUM_SRC] = '{
        16'h0003, 16'h0006, 16'h0009, 16'h000F, 16'h0012,
        16'h0015, 16'h0018, 16'h001B, 16'h0021, 16'h0024,
        16'h0027, 16'h002A, 16'h0030, 16'h0033, 16'h0036};

    localparam logic [NUM_SRC-1:0] FLAG_RST   = 15'h0000;
    localparam logic [NUM_SRC-1:0] ENABLE_RST = 15'h0000;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        PVI_IDLE   = 2'b00,
        PVI_VECTOR = 2'b01,
        PVI_SERVE  = 2'b10
    } pvi_state_t;
endpackage

// *** hw/pvi_prio_enc.sv ***
module pvi_prio_enc (
    input  wire logic [pvi_pkg::NUM_SRC-1:0] req,    // Qualified requests
    output logic                             hit,    // Any request
    output logic [3:0]                       idx     // Lowest index wins
);
    import pvi_pkg::*;

    // [R12] Highest priority pick
    always_comb begin
        hit = 1'b0;
        idx = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                hit = 1'b1;
                idx = 4'(i);
            end
        end
    end
endmodule

// *** hw/pvi_ctrl.sv ***
// Function
// [R1] Fifteen request sources, nine external and six internal, each with flag and vector.
// [R2] Fixed vectors: reset 0000, watchdog 0003, up to external line d 0036.
// [R3] Fixed priority follows vector order; reset highest, external line d lowest.
// [R4] Global enable set and cleared by instructions; source needs it and its enable bit.
// [R5] Three status registers record one request flag per source.
// [R6] Two enable registers gate which recorded flags may interrupt.
// [R7] Accepted interrupt forces next fetch from that source's vector.
// [R8] Register c flags set regardless of masks, except the excluded change flag.
// [R9] Service routine clears the serviced flag before return or re-enable.
// [R10] Return instruction ends the routine and sets the global enable.
// [R11] Acceptance clears global enable and saves the return address.
// [R12] Several pending: vector to highest priority, leave others pending.
module pvi_ctrl (
    input  wire logic                         aclk,                  // Core clock
    input  wire logic                         aresetn,               // Sync reset, low
    input  wire logic [pvi_pkg::AXI_AW-1:0]   s_axi_awaddr,          // Write address
    input  wire logic                         s_axi_awvalid,         // Write address valid
    output logic                              s_axi_awready,         // Write address ready
    input  wire logic [pvi_pkg::AXI_DW-1:0]   s_axi_wdata,           // Write data
    input  wire logic [3:0]                   s_axi_wstrb,           // Write strobes
    input  wire logic                         s_axi_wvalid,          // Write data valid
    output logic                              s_axi_wready,          // Write data ready
    output logic [1:0]                        s_axi_bresp,           // Write response
    output logic                              s_axi_bvalid,          // Write response valid
    input  wire logic                         s_axi_bready,          // Write response ready
    input  wire logic [pvi_pkg::AXI_AW-1:0]   s_axi_araddr,          // Read address
    input  wire logic                         s_axi_arvalid,         // Read address valid
    output logic                              s_axi_arready,         // Read address ready
    output logic [pvi_pkg::AXI_DW-1:0]        s_axi_rdata,           // Read data
    output logic [1:0]                        s_axi_rresp,           // Read response
    output logic                              s_axi_rvalid,          // Read data valid
    input  wire logic                         s_axi_rready,          // Read data ready
    input  wire logic [pvi_pkg::NUM_INT-1:0]  int_req,               // Internal event pulses
    input  wire logic [pvi_pkg::NUM_EXT-1:0]  ext_req,               // External pins, async
    input  wire logic                         global_irq_on_instr,   // Enable instr executed
    input  wire logic                         global_irq_off_instr,  // Disable instr executed
    input  wire logic                         irq_return_instr,      // Return instr executed
    input  wire logic                         fetch_strobe,          // Core fetch accepted
    input  wire logic [pvi_pkg::VEC_W-1:0]    fetch_pc,              // Core sequential pc
    output logic                              fetch_redirect,        // Use fetch_vector now
    output logic [pvi_pkg::VEC_W-1:0]         fetch_vector,          // Redirect address
    output logic [pvi_pkg::VEC_W-1:0]         return_addr,           // Saved return address
    output logic                              global_irq_en,         // Global enable state
    output logic                              in_service             // Routine under way
);
    import pvi_pkg::*;

    // External lines: first stage feeds only second stage
    logic [NUM_EXT-1:0] ext_meta;
    logic [NUM_EXT-1:0] ext_sync;
    logic [NUM_EXT-1:0] ext_prev;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_meta <= '0;
            ext_sync <= '0;
            ext_prev <= '0;
        end else begin
            ext_meta <= ext_req;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // [R1] Source mapping, rising edge of each external line
    logic [NUM_EXT-1:0] ext_rise;
    logic [NUM_SRC-1:0] event_in;
    assign ext_rise = ext_sync & ~ext_prev;
    always_comb begin
        event_in              = '0;
        event_in[SRC_WDT]     = int_req[0];
        event_in[SRC_MTMR]    = int_req[1];
        event_in[SRC_TBASE]   = int_req[2];
        event_in[SRC_UERR]    = int_req[3];
        event_in[SRC_SPI]     = int_req[4];
        event_in[SRC_ADC]     = int_req[5];
        event_in[SRC_EXT_A]   = ext_rise[0];
        event_in[SRC_EXT_B]   = ext_rise[1];
        event_in[SRC_UTX]     = ext_rise[2];
        event_in[SRC_URX]     = ext_rise[3];
        event_in[SRC_TMR3]    = ext_rise[4];
        event_in[SRC_TMR4]    = ext_rise[5];
        event_in[SRC_EXT_C]   = ext_rise[6];
        event_in[SRC_TMR2]    = ext_rise[7];
        event_in[SRC_EXT_D]   = ext_rise[8];
    end

    logic [NUM_SRC-1:0] flags;
    logic [NUM_SRC-1:0] enables;
    logic               gie;
    pvi_state_t         state;
    logic [3:0]         win_idx;
    logic               win_hit;
    logic [3:0]         serv_idx;

    // AXI4-Lite write path: address and data taken in either order
    logic               aw_held;
    logic               w_held;
    logic [AXI_AW-1:0]  aw_addr;
    logic [AXI_DW-1:0]  w_data;
    logic [3:0]         w_strb;
    logic               wr_go;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_go         = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
        is_mapped = (a == OFS_FLAG_A) || (a == OFS_FLAG_B) || (a == OFS_FLAG_C) ||
                    (a == OFS_ENABLE_A) || (a == OFS_ENABLE_B) || (a == OFS_STATUS) ||
                    (a == OFS_SET_TEST);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Software write decode: write 1 clears a flag, set-test write raises one
    logic               wr_lane0;
    logic [NUM_SRC-1:0] sw_clr;
    logic [NUM_SRC-1:0] sw_set;
    assign wr_lane0 = wr_go && w_strb[0];
    always_comb begin
        sw_clr = '0;
        sw_set = '0;
        if (wr_lane0 && aw_addr == OFS_FLAG_A) begin
            sw_clr[FLAG_A_LO +: FLAG_W] = w_data[FLAG_W-1:0];
        end
        if (wr_lane0 && aw_addr == OFS_FLAG_B) begin
            sw_clr[FLAG_B_LO +: FLAG_W] = w_data[FLAG_W-1:0];
        end
        if (wr_lane0 && aw_addr == OFS_FLAG_C) begin
            sw_clr[FLAG_C_LO +: FLAG_W] = w_data[FLAG_W-1:0];
        end
        if (wr_go && aw_addr == OFS_SET_TEST) begin
            sw_set = w_data[NUM_SRC-1:0];
        end
    end

    // [R6] Two enable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enables <= ENABLE_RST;
        end else begin
            if (wr_lane0 && aw_addr == OFS_ENABLE_A) begin
                enables[EN_A_W-1:0] <= w_data[EN_A_W-1:0];
            end
            if (wr_lane0 && aw_addr == OFS_ENABLE_B) begin
                enables[NUM_SRC-1:EN_A_W] <= w_data[EN_B_W-1:0];
            end
        end
    end

    // [R8] Excluded flag needs enable; others record unconditionally
    logic [NUM_SRC-1:0] set_gate;
    always_comb begin
        set_gate           = '1;
        set_gate[EXCL_SRC] = enables[EXCL_SRC] && gie;
    end

    // [R5] Sticky flags, a new event wins over a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= FLAG_RST;
        end else begin
            flags <= (flags & ~sw_clr) | ((event_in | sw_set) & set_gate);
        end
    end

    // [R4] Qualify by enable bit and global enable
    logic [NUM_SRC-1:0] qualified;
    assign qualified = flags & enables & {NUM_SRC{gie}};

    // [R3] Index order is priority order
    pvi_prio_enc u_prio (
        .req (qualified),
        .hit (win_hit),
        .idx (win_idx)
    );

    logic take;
    assign take = (state == PVI_IDLE) && win_hit;

    // [R4] Global enable instructions
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gie <= 1'b0;
        end else if (take) begin
            // [R11] Block nesting until return
            gie <= 1'b0;
        end else if (global_irq_on_instr || irq_return_instr) begin
            // [R10] Return re-enables
            gie <= 1'b1;
        end else if (global_irq_off_instr) begin
            gie <= 1'b0;
        end
    end

    // Redirect handshake: vector held until the core fetches from it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state       <= PVI_IDLE;
            serv_idx    <= '0;
            return_addr <= VEC_RESET;
        end else begin
            unique case (state)
                PVI_IDLE: begin
                    if (take) begin
                        state       <= PVI_VECTOR;
                        serv_idx    <= win_idx;
                        // [R11] Save return address
                        return_addr <= fetch_pc;
                    end
                end
                PVI_VECTOR: begin
                    if (fetch_strobe) begin
                        state <= PVI_SERVE;
                    end
                end
                PVI_SERVE: begin
                    // [R10] Return ends the routine
                    if (irq_return_instr) begin
                        state <= PVI_IDLE;
                    end
                end
                default: begin
                    state <= PVI_IDLE;
                end
            endcase
        end
    end

    // [R7] Fetch forced to the vector
    // [R2] Vector lookup
    assign fetch_redirect = (state == PVI_VECTOR);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fetch_vector <= VEC_RESET;
        end else if (take) begin
            fetch_vector <= VEC_TABLE[win_idx];
        end
    end

    assign global_irq_en = gie;
    assign in_service    = (state != PVI_IDLE);

    // Read path; one read at a time
    logic [AXI_DW-1:0] rd_word;
    always_comb begin
        rd_word = '0;
        unique case (s_axi_araddr)
            OFS_FLAG_A:   rd_word[FLAG_W-1:0] = flags[FLAG_A_LO +: FLAG_W];
            OFS_FLAG_B:   rd_word[FLAG_W-1:0] = flags[FLAG_B_LO +: FLAG_W];
            OFS_FLAG_C:   rd_word[FLAG_W-1:0] = flags[FLAG_C_LO +: FLAG_W];
            OFS_ENABLE_A: rd_word[EN_A_W-1:0] = enables[EN_A_W-1:0];
            OFS_ENABLE_B: rd_word[EN_B_W-1:0] = enables[NUM_SRC-1:EN_A_W];
            OFS_STATUS:   rd_word[7:0] = {in_service, gie, win_hit, 1'b0, serv_idx};
            default:      rd_word = '0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// *** dv/pvi_core_model.sv ***
module pvi_core_model (
    input  wire logic        aclk,           // Core clock
    input  wire logic        aresetn,        // Sync reset
    input  wire logic        fetch_redirect, // Vector fetch wanted
    input  wire logic [3:0]  fetch_lag,      // Stall before taking it
    output logic             fetch_strobe,   // Fetch accepted
    output logic [15:0]      fetch_pc        // Next sequential pc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] stall;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fetch_pc     <= 16'h0100;
            fetch_strobe <= 1'b0;
            stall        <= 4'h0;
        end else begin
            fetch_pc     <= fetch_pc + 16'h0001;
            fetch_strobe <= 1'b0;
            // A slow core stalls, so the redirect must hold
            if (fetch_redirect && !fetch_strobe) begin
                fetch_strobe <= (stall >= fetch_lag);
                stall        <= (stall >= fetch_lag) ? 4'h0 : stall + 4'h1;
            end
        end
    end
endmodule

// *** dv/pvi_ctrl_props.sv ***
module pvi_ctrl_props (
    input wire logic        aclk,                 // Core clock
    input wire logic        aresetn,              // Sync reset
    input wire logic        global_irq_on_instr,  // Enable instr
    input wire logic        global_irq_off_instr, // Disable instr
    input wire logic        irq_return_instr,     // Return instr
    input wire logic        fetch_strobe,         // Fetch accepted
    input wire logic [15:0] fetch_pc,             // Sequential pc
    input wire logic        fetch_redirect,       // Redirect pending
    input wire logic [15:0] fetch_vector,         // Redirect target
    input wire logic [15:0] return_addr,          // Saved pc
    input wire logic        global_irq_en,        // Global enable
    input wire logic        in_service            // Routine running
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    take_gated_a: assert property ($rose(fetch_redirect) |-> $past(global_irq_en) && !global_irq_en)
        else $error("take without enable");
    ret_addr_a: assert property ($rose(fetch_redirect) |-> return_addr == $past(fetch_pc))
        else $error("return address wrong");
    vec_legal_a: assert property (fetch_redirect |-> fetch_vector inside {16'h0003, 16'h0006, 16'h0009,
        16'h000F, 16'h0012, 16'h0015, 16'h0018, 16'h001B, 16'h0021, 16'h0024, 16'h0027, 16'h002A, 16'h0030,
        16'h0033, 16'h0036}) else $error("vector off table");
    redir_hold_a: assert property (fetch_redirect && !fetch_strobe
        |=> fetch_redirect && $stable(fetch_vector)) else $error("redirect dropped");
    enter_serve_a: assert property (fetch_redirect && fetch_strobe |=> !fetch_redirect && in_service)
        else $error("no service entry");
    // Redirect may stand while the core stalls; only a fresh take is forbidden
    no_retake_a: assert property (in_service && !fetch_redirect && !irq_return_instr |=> !fetch_redirect)
        else $error("nested take");
    ret_on_a: assert property (irq_return_instr && in_service && !fetch_redirect
        |=> global_irq_en && !in_service) else $error("return failed");
    gie_on_a: assert property (global_irq_on_instr && !global_irq_off_instr && !global_irq_en
        |=> global_irq_en) else $error("enable ignored");
    gie_off_a: assert property (global_irq_off_instr && !global_irq_on_instr && !irq_return_instr
        |=> !global_irq_en) else $error("disable ignored");
endmodule

bind pvi_ctrl pvi_ctrl_props i_props (.aclk, .aresetn, .global_irq_on_instr, .global_irq_off_instr, .irq_return_instr,
    .fetch_strobe, .fetch_pc, .fetch_redirect, .fetch_vector, .return_addr, .global_irq_en, .in_service);

// *** dv/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pvi_pkg::*;
    logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, fetch_strobe;
    logic              global_irq_on_instr, global_irq_off_instr, irq_return_instr;
    logic              fetch_redirect, global_irq_en, in_service;
    logic [7:0]        s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [1:0]        s_axi_bresp, s_axi_rresp, q_wr[$];
    logic [3:0]        s_axi_wstrb, fetch_lag;
    logic [5:0]        int_req;
    logic [8:0]        ext_req;
    logic [15:0]       fetch_pc, fetch_vector, return_addr, q_vec[$];
    logic [33:0]       q_rd[$];
    logic [14:0]       pend;
    logic [2:0]        gate;
    int                err_total, comparisons, cycles, idx;
    localparam logic [15:0] EXP_VEC [15] = '{16'h0003, 16'h0006, 16'h0009, 16'h000F, 16'h0012, 16'h0015,
        16'h0018, 16'h001B, 16'h0021, 16'h0024, 16'h0027, 16'h002A, 16'h0030, 16'h0033, 16'h0036};
    // Source to pin: below 16 an internal pulse bit, else external line plus 16
    localparam int PIN_OF [15] = '{0, 16, 1, 17, 2, 18, 19, 3, 20, 4, 21, 22, 5, 23, 24};

    pvi_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .int_req, .ext_req,
        .global_irq_on_instr, .global_irq_off_instr, .irq_return_instr, .fetch_strobe, .fetch_pc, .fetch_redirect,
        .fetch_vector, .return_addr, .global_irq_en, .in_service);
    pvi_core_model i_core (.aclk, .aresetn, .fetch_redirect, .fetch_lag, .fetch_strobe, .fetch_pc);

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic chk(input logic [33:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        q_wr.push_back(resp);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] exp);
        q_rd.push_back(exp);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Core decode pulses: enable, disable, return
    task automatic instr(input logic [2:0] k);
        {global_irq_on_instr, global_irq_off_instr, irq_return_instr} <= k;
        @(posedge aclk);
        {global_irq_on_instr, global_irq_off_instr, irq_return_instr} <= 3'b000;
        @(posedge aclk);
    endtask

    // External lines stay high; caller drops them later
    task automatic raise(input int i);
        if (PIN_OF[i] < 16) int_req[PIN_OF[i]] <= 1'b1;
        else ext_req[PIN_OF[i] - 16] <= 1'b1;
        @(posedge aclk);
        int_req <= '0;
        @(posedge aclk);
    endtask

    task automatic wait_service();
        do @(posedge aclk); while (!in_service);
    endtask

    function automatic logic [7:0] fa(input int i);
        return OFS_FLAG_A + 8'(4 * (i / 5));
    endfunction

    function automatic int lowest(input logic [14:0] p);
        for (int k = 0; k < 15; k++) if (p[k]) return k;
        return 0;
    endfunction

    always @(posedge aclk) begin
        cycles++;
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, q_rd.pop_front(), "read");
        if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, q_wr.pop_front()}, "bresp");
        if (fetch_redirect && fetch_strobe) begin
            chk({18'h0, fetch_vector}, {18'h0, q_vec.pop_front()}, "vector");
        end
        if (cycles == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        {aresetn, fetch_lag, int_req, ext_req, s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        {global_irq_on_instr, global_irq_off_instr, irq_return_instr} = 3'b000;
        s_axi_wstrb = 4'hF;
        void'($urandom(22));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int k = 0; k < 8; k++) rd(8'(4 * k), (k == 7) ? {RESP_SLVERR, 32'h0} : 34'h0);
        wr(8'h1C, 32'h1, RESP_SLVERR);
        pend = 15'($urandom);
        wr(OFS_ENABLE_A, {17'h0, pend}, RESP_OKAY);
        rd(OFS_ENABLE_A, {26'h0, pend[7:0]});
        wr(OFS_ENABLE_B, {17'h0, pend}, RESP_OKAY);
        rd(OFS_ENABLE_B, {27'h0, pend[6:0]});
        // Test set of every flag; the change flag stays clear while disabled
        wr(OFS_SET_TEST, 32'h7FFF, RESP_OKAY);
        for (int k = 0; k < 3; k++) begin
            rd(fa(5 * k), {29'h0, (k == 2) ? 5'h1D : 5'h1F});
            wr(fa(5 * k), 32'h1F, RESP_OKAY);
            rd(fa(5 * k), 34'h0);
        end
        $display("test registers done");
        for (int i = 0; i < 15; i++) begin
            fetch_lag <= 4'($urandom_range(0, 3));
            wr(OFS_ENABLE_A, (32'h1 << i) & 32'hFF, RESP_OKAY);
            wr(OFS_ENABLE_B, (32'h1 << i) >> 8, RESP_OKAY);
            instr(3'b100);
            q_vec.push_back(EXP_VEC[i]);
            raise(i);
            wait_service();
            rd(OFS_STATUS, {26'h0, 8'h80 | 8'(i)});
            rd(fa(i), {29'h0, 5'(1 << (i % 5))});
            wr(fa(i), 32'h1 << (i % 5), RESP_OKAY);
            rd(fa(i), 34'h0);
            instr(3'b001);
            ext_req <= '0;
        end
        $display("test vectors done");
        wr(OFS_ENABLE_A, 32'h0, RESP_OKAY);
        wr(OFS_ENABLE_B, 32'h0, RESP_OKAY);
        instr(3'b010);
        pend = 15'($urandom) | 15'h0801;
        for (int i = 0; i < 15; i++) if (pend[i]) raise(i);
        repeat (4) @(posedge aclk);
        pend[EXCL_SRC] = 1'b0;
        for (int k = 0; k < 3; k++) rd(fa(5 * k), {29'h0, 5'(pend >> (5 * k))});
        wr(OFS_ENABLE_A, 32'hFF, RESP_OKAY);
        wr(OFS_ENABLE_B, 32'h7F, RESP_OKAY);
        chk({33'h0, fetch_redirect}, 34'h0, "take while disabled");
        gate = 3'b100;
        while (pend != 0) begin
            idx = lowest(pend);
            pend[idx] = 1'b0;
            q_vec.push_back(EXP_VEC[idx]);
            instr(gate);
            wait_service();
            // Flag cleared before the routine re-enables
            wr(fa(idx), 32'h1 << (idx % 5), RESP_OKAY);
            instr(3'b100);
            gate = 3'b001;
        end
        instr(3'b001);
        ext_req <= '0;
        $display("test priority done");
        wrap_up();
    end
endmodule
